//--- hdl/timer_pkg.sv
package timer_pkg;

    typedef enum logic [1:0] {
        mode_13bit = 2'b00,
        mode_16bit = 2'b01,
        mode_reload = 2'b10,
        mode_split = 2'b11
    } timer_mode_t;

    typedef enum logic [1:0] {
        scale_div12 = 2'b00,
        scale_div4 = 2'b01,
        scale_div48 = 2'b10,
        scale_ext8 = 2'b11
    } clock_scale_t;

    localparam logic [1:0] c_clk_sys = 2'b00;
    localparam logic [1:0] c_clk_div12 = 2'b01;
    localparam logic [1:0] c_clk_ext8 = 2'b10;

    localparam logic [3:0] div12_last = 4'hb;
    localparam logic [1:0] div4_last = 2'h3;
    localparam logic [5:0] div48_last = 6'h2f;
    localparam logic [2:0] ext8_last = 3'h7;

    localparam int low13_bits = 5;
    localparam logic [7:0] byte_reset = 8'h00;
    localparam logic [2:0] sync_reset = 3'h0;

endpackage

//--- hdl/clock_prescaler.sv
`timescale 1ns/1ps

module clock_prescaler (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [1:0] clock_scale_bits,
    input wire logic ext_osc,
    output logic prescale_tick,
    output logic tick_div12,
    output logic tick_ext8
);

    typedef struct packed {
        logic [2:0] osc_sync;
        logic osc_lvl;
        logic [3:0] c12;
        logic [1:0] c4;
        logic [5:0] c48;
        logic [2:0] c8;
    } pre_state_t;

    pre_state_t cur;
    pre_state_t next_cur;
    logic osc_rise;
    logic tick4;
    logic tick48;

    always_comb begin
        next_cur = cur;
        next_cur.osc_sync = {cur.osc_sync[1:0], ext_osc};
        osc_rise = !cur.osc_lvl && (cur.osc_sync[1] == cur.osc_sync[2]) && cur.osc_sync[2];
        if (cur.osc_sync[1] == cur.osc_sync[2]) begin
            next_cur.osc_lvl = cur.osc_sync[2];
        end
        next_cur.c12 = (cur.c12 == timer_pkg::div12_last) ? 4'h0 : cur.c12 + 4'h1;
        next_cur.c4 = cur.c4 + 2'h1;
        next_cur.c48 = (cur.c48 == timer_pkg::div48_last) ? 6'h00 : cur.c48 + 6'h01;
        if (osc_rise) begin
            next_cur.c8 = cur.c8 + 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign tick_div12 = (cur.c12 == timer_pkg::div12_last);
    assign tick4 = (cur.c4 == timer_pkg::div4_last);
    assign tick48 = (cur.c48 == timer_pkg::div48_last);
    // one enable per eighth rising oscillator edge, held a single cycle
    assign tick_ext8 = osc_rise && (cur.c8 == timer_pkg::ext8_last);

    always_comb begin
        unique case (timer_pkg::clock_scale_t'(clock_scale_bits))
            timer_pkg::scale_div12: prescale_tick = tick_div12;
            timer_pkg::scale_div4: prescale_tick = tick4;
            timer_pkg::scale_div48: prescale_tick = tick48;
            timer_pkg::scale_ext8: prescale_tick = tick_ext8;
        endcase
    end

endmodule // clock_prescaler

//--- hdl/reload_timer.sv
`timescale 1ns/1ps

module reload_timer (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic run,
    input wire logic split,
    input wire logic [1:0] clk_sel,
    input wire logic tick_div12,
    input wire logic tick_ext8,
    input wire logic [7:0] reload_low,
    input wire logic [7:0] reload_high,
    output logic [7:0] count_low,
    output logic [7:0] count_high,
    output logic ovf_low,
    output logic ovf_high
);

    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic ovf_lo;
        logic ovf_hi;
    } rt_state_t;

    rt_state_t cur;
    rt_state_t next_cur;
    logic tick;

    always_comb begin
        next_cur = cur;
        next_cur.ovf_lo = 1'b0;
        next_cur.ovf_hi = 1'b0;
        unique case (clk_sel)
            timer_pkg::c_clk_sys: tick = 1'b1;
            timer_pkg::c_clk_div12: tick = tick_div12;
            timer_pkg::c_clk_ext8: tick = tick_ext8;
            default: tick = 1'b0;
        endcase
        if (run && tick) begin
            if (split) begin
                // two independent 8-bit halves, each with its own reload
                next_cur.lo = (cur.lo == 8'hff) ? reload_low : cur.lo + 8'h01;
                next_cur.ovf_lo = (cur.lo == 8'hff);
                next_cur.hi = (cur.hi == 8'hff) ? reload_high : cur.hi + 8'h01;
                next_cur.ovf_hi = (cur.hi == 8'hff);
            end else if ({cur.hi, cur.lo} == 16'hffff) begin
                next_cur.lo = reload_low;
                next_cur.hi = reload_high;
                next_cur.ovf_hi = 1'b1;
            end else begin
                {next_cur.hi, next_cur.lo} = {cur.hi, cur.lo} + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign count_low = cur.lo;
    assign count_high = cur.hi;
    assign ovf_low = cur.ovf_lo;
    assign ovf_high = cur.ovf_hi;

    full_reload_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        run && tick && !split && {cur.hi, cur.lo} == 16'hffff
        |=> {count_high, count_low} == $past({reload_high, reload_low}) && ovf_high)
        else $error("full reload missed");

endmodule // reload_timer

//--- hdl/dual_counter_timer_unit.sv
`timescale 1ns/1ps

module dual_counter_timer_unit (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [3:0] timer_mode_select_bits,
    input wire logic [1:0] timer_clock_select_bits,
    input wire logic [1:0] clock_scale_bits,
    input wire logic timer_a_run_bit,
    input wire logic timer_b_run_bit,
    input wire logic timer_a_count_select,
    input wire logic timer_b_count_select,
    input wire logic timer_a_gate_bit,
    input wire logic timer_b_gate_bit,
    input wire logic timer_a_irq_enable,
    input wire logic timer_b_irq_enable,
    input wire logic count_pin_a,
    input wire logic count_pin_b,
    input wire logic gate_pin_a,
    input wire logic gate_pin_b,
    input wire logic ext_osc,
    input wire logic [3:0] byte_write,
    input wire logic [7:0] write_data,
    input wire logic timer_a_flag_clear,
    input wire logic timer_b_flag_clear,
    input wire logic timer_c_run,
    input wire logic timer_c_split,
    input wire logic [1:0] timer_c_clock_select,
    input wire logic [7:0] timer_c_reload_low,
    input wire logic [7:0] timer_c_reload_high,
    output logic [7:0] timer_a_low_byte,
    output logic [7:0] timer_a_high_byte,
    output logic [7:0] timer_b_low_byte,
    output logic [7:0] timer_b_high_byte,
    output logic timer_a_overflow_flag,
    output logic timer_b_overflow_flag,
    output logic timer_a_irq,
    output logic timer_b_irq,
    output logic timer_b_overflow_pulse,
    output logic [7:0] timer_c_low_byte,
    output logic [7:0] timer_c_high_byte,
    output logic timer_c_low_overflow,
    output logic timer_c_high_overflow
);

    typedef struct packed {
        logic [2:0] cnt_a_sync;
        logic [2:0] cnt_b_sync;
        logic [2:0] gate_a_sync;
        logic [2:0] gate_b_sync;
        logic cnt_a_lvl;
        logic cnt_b_lvl;
        logic gate_a_lvl;
        logic gate_b_lvl;
        logic [7:0] a_lo;
        logic [7:0] a_hi;
        logic [7:0] b_lo;
        logic [7:0] b_hi;
        logic flag_a;
        logic flag_b;
        logic b_ovf;
    } unit_state_t;

    unit_state_t cur;
    unit_state_t next_cur;
    timer_pkg::timer_mode_t mode_a;
    timer_pkg::timer_mode_t mode_b;
    logic prescale_tick;
    logic tick_div12;
    logic tick_ext8;
    logic fall_a;
    logic fall_b;
    logic base_a;
    logic base_b;
    logic tick_a;
    logic tick_b;
    logic run_a;
    logic run_b;
    logic ovf_a;
    logic ovf_b;
    logic ovf_split_hi;
    logic [16:0] res_a;
    logic [16:0] res_b;

    assign mode_a = timer_pkg::timer_mode_t'(timer_mode_select_bits[1:0]);
    assign mode_b = timer_pkg::timer_mode_t'(timer_mode_select_bits[3:2]);

    // returns {overflow, high, low} after one count step
    function automatic logic [16:0] step(input timer_pkg::timer_mode_t mode,
                                         input logic [7:0] lo, input logic [7:0] hi);
        logic [13:0] v13;
        logic [16:0] v16;
        logic [8:0] v8;
        v13 = {1'b0, hi, lo[timer_pkg::low13_bits-1:0]} + 14'h0001;
        v16 = {1'b0, hi, lo} + 17'h0_0001;
        v8 = {1'b0, lo} + 9'h001;
        unique case (mode)
            timer_pkg::mode_13bit: step = {v13[13], v13[12:5], lo[7:5], v13[4:0]};
            timer_pkg::mode_16bit: step = v16;
            timer_pkg::mode_reload: step = v8[8] ? {1'b1, hi, hi} : {1'b0, hi, v8[7:0]};
            timer_pkg::mode_split: step = {v8[8], hi, v8[7:0]};
        endcase
    endfunction

    // one prescaler serves both general timers, so their prescaled ticks stay in phase
    clock_prescaler u_prescaler (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clock_scale_bits(clock_scale_bits),
        .ext_osc(ext_osc),
        .prescale_tick(prescale_tick),
        .tick_div12(tick_div12),
        .tick_ext8(tick_ext8)
    );

    // the third timer borrows only the divided ticks and keeps no flags of its own
    reload_timer u_timer_c (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .run(timer_c_run),
        .split(timer_c_split),
        .clk_sel(timer_c_clock_select),
        .tick_div12(tick_div12),
        .tick_ext8(tick_ext8),
        .reload_low(timer_c_reload_low),
        .reload_high(timer_c_reload_high),
        .count_low(timer_c_low_byte),
        .count_high(timer_c_high_byte),
        .ovf_low(timer_c_low_overflow),
        .ovf_high(timer_c_high_overflow)
    );

    always_comb begin
        next_cur = cur;
        // three-stage pin sampling; a level counts once the last two agree,
        // which is why the source must hold each level two clocks
        next_cur.cnt_a_sync = {cur.cnt_a_sync[1:0], count_pin_a};
        next_cur.cnt_b_sync = {cur.cnt_b_sync[1:0], count_pin_b};
        next_cur.gate_a_sync = {cur.gate_a_sync[1:0], gate_pin_a};
        next_cur.gate_b_sync = {cur.gate_b_sync[1:0], gate_pin_b};
        if (cur.cnt_a_sync[2] == cur.cnt_a_sync[1]) next_cur.cnt_a_lvl = cur.cnt_a_sync[2];
        if (cur.cnt_b_sync[2] == cur.cnt_b_sync[1]) next_cur.cnt_b_lvl = cur.cnt_b_sync[2];
        if (cur.gate_a_sync[2] == cur.gate_a_sync[1]) next_cur.gate_a_lvl = cur.gate_a_sync[2];
        if (cur.gate_b_sync[2] == cur.gate_b_sync[1]) next_cur.gate_b_lvl = cur.gate_b_sync[2];
        fall_a = cur.cnt_a_lvl && !next_cur.cnt_a_lvl;
        fall_b = cur.cnt_b_lvl && !next_cur.cnt_b_lvl;
        base_a = timer_clock_select_bits[0] ? 1'b1 : prescale_tick;
        base_b = timer_clock_select_bits[1] ? 1'b1 : prescale_tick;
        // pin edges arrive three clocks after the pin moves, because of the filter
        tick_a = timer_a_count_select ? fall_a : base_a;
        tick_b = timer_b_count_select ? fall_b : base_b;
        run_a = timer_a_run_bit && (!timer_a_gate_bit || cur.gate_a_lvl);
        run_b = timer_b_run_bit && (!timer_b_gate_bit || cur.gate_b_lvl);
        res_a = step(mode_a, cur.a_lo, cur.a_hi);
        ovf_a = 1'b0;
        ovf_split_hi = 1'b0;
        if (run_a && tick_a) begin
            next_cur.a_lo = res_a[7:0];
            if (mode_a != timer_pkg::mode_split) next_cur.a_hi = res_a[15:8];
            ovf_a = res_a[16];
        end
        if (mode_a == timer_pkg::mode_split && timer_b_run_bit && base_a) begin
            // high half borrows the second run bit and only times clocks
            next_cur.a_hi = cur.a_hi + 8'h01;
            ovf_split_hi = (cur.a_hi == 8'hff);
        end
        res_b = step(mode_b, cur.b_lo, cur.b_hi);
        ovf_b = 1'b0;
        if (mode_a == timer_pkg::mode_split) begin
            // run control moves to the mode bits; pin counting is lost
            if (mode_b != timer_pkg::mode_split && base_b) begin
                {ovf_b, next_cur.b_hi, next_cur.b_lo} = res_b;
            end
        end else if (mode_b != timer_pkg::mode_split && run_b && tick_b) begin
            {ovf_b, next_cur.b_hi, next_cur.b_lo} = res_b;
        end
        next_cur.b_ovf = ovf_b;
        // writes come last, so software beats a count step in the same cycle
        if (byte_write[0]) next_cur.a_lo = write_data;
        if (byte_write[1]) next_cur.a_hi = write_data;
        if (byte_write[2]) next_cur.b_lo = write_data;
        if (byte_write[3]) next_cur.b_hi = write_data;
        // a set in the clearing cycle is kept
        next_cur.flag_a = ovf_a || (cur.flag_a && !timer_a_flag_clear);
        if (mode_a == timer_pkg::mode_split) begin
            next_cur.flag_b = ovf_split_hi || (cur.flag_b && !timer_b_flag_clear);
        end else begin
            next_cur.flag_b = ovf_b || (cur.flag_b && !timer_b_flag_clear);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign timer_a_low_byte = cur.a_lo;
    assign timer_a_high_byte = cur.a_hi;
    assign timer_b_low_byte = cur.b_lo;
    assign timer_b_high_byte = cur.b_hi;
    assign timer_a_overflow_flag = cur.flag_a;
    assign timer_b_overflow_flag = cur.flag_b;
    // irq is not registered: a change of enable acts in the same cycle
    assign timer_a_irq = cur.flag_a && timer_a_irq_enable;
    assign timer_b_irq = cur.flag_b && timer_b_irq_enable;
    assign timer_b_overflow_pulse = cur.b_ovf;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    wrap_13bit_a: assert property (mode_a == timer_pkg::mode_13bit && run_a && tick_a
        && {cur.a_hi, cur.a_lo[4:0]} == 13'h1fff && byte_write == 4'h0
        |=> timer_a_high_byte == 8'h00 && timer_a_low_byte[4:0] == 5'h00
        && timer_a_overflow_flag) else $error("13-bit wrap wrong");
    flag_sticky_a: assert property (ovf_a |=> timer_a_overflow_flag)
        else $error("flag a lost on overflow");
    wrap_16bit_a: assert property (mode_a == timer_pkg::mode_16bit && run_a && tick_a
        && {cur.a_hi, cur.a_lo} == 16'hffff && byte_write == 4'h0
        |=> {timer_a_high_byte, timer_a_low_byte} == 16'h0000 && timer_a_overflow_flag)
        else $error("16-bit wrap wrong");
    reload_low_a: assert property (mode_a == timer_pkg::mode_reload && run_a && tick_a
        && cur.a_lo == 8'hff && byte_write == 4'h0
        |=> timer_a_low_byte == $past(cur.a_hi) && timer_a_overflow_flag)
        else $error("reload from high byte failed");
    irq_gate_a: assert property (timer_b_irq == (timer_b_overflow_flag && timer_b_irq_enable)
        && timer_a_irq == (timer_a_overflow_flag && timer_a_irq_enable))
        else $error("irq not gated by enable");
    stopped_hold_a: assert property (!timer_a_run_bit && mode_a != timer_pkg::mode_split
        && byte_write == 4'h0 |=> $stable(timer_a_low_byte) && $stable(timer_a_high_byte))
        else $error("stopped timer moved");
    pin_count_a: assert property (mode_a == timer_pkg::mode_16bit && timer_a_count_select
        && run_a && fall_a && cur.a_lo != 8'hff && byte_write == 4'h0
        |=> timer_a_low_byte == $past(cur.a_lo) + 8'h01) else $error("pin edge not counted");
    split_high_a: assert property (ovf_split_hi && mode_a == timer_pkg::mode_split
        |=> timer_b_overflow_flag && timer_a_high_byte == 8'h00)
        else $error("split high overflow lost");
    b_idle_split_a: assert property (mode_a == timer_pkg::mode_split
        && mode_b == timer_pkg::mode_split && byte_write == 4'h0
        |=> $stable(timer_b_low_byte) && $stable(timer_b_high_byte) && !timer_b_overflow_pulse)
        else $error("second timer moved in mode 3");
    b_noflag_a: assert property (mode_a == timer_pkg::mode_split && ovf_b && !ovf_split_hi
        && !cur.flag_b |=> !timer_b_overflow_flag && timer_b_overflow_pulse)
        else $error("second timer set flag while first split");

    // the count checks below skip write cycles, since a byte write overrides the count step
    clear_flag_a: assert property (timer_a_flag_clear && !ovf_a
        |=> !timer_a_overflow_flag) else $error("flag a not cleared");
    b_mode3_a: assert property (mode_b == timer_pkg::mode_split
        && mode_a != timer_pkg::mode_split && byte_write == 4'h0
        |=> $stable(timer_b_low_byte) && $stable(timer_b_high_byte))
        else $error("second timer moved in mode 3");
    gate_hold_a: assert property (timer_a_gate_bit && !cur.gate_a_lvl
        && mode_a != timer_pkg::mode_split && byte_write == 4'h0
        |=> $stable(timer_a_low_byte) && $stable(timer_a_high_byte))
        else $error("gated timer moved");
    split_b_count_a: assert property (mode_a == timer_pkg::mode_split
        && mode_b == timer_pkg::mode_16bit && base_b && byte_write == 4'h0
        |=> {timer_b_high_byte, timer_b_low_byte} == $past({cur.b_hi, cur.b_lo}) + 16'h0001)
        else $error("second timer stalled while first split");
    pin_count_b_a: assert property (mode_b == timer_pkg::mode_16bit && timer_b_count_select
        && run_b && fall_b && mode_a != timer_pkg::mode_split && cur.b_lo != 8'hff
        && byte_write == 4'h0 |=> timer_b_low_byte == $past(cur.b_lo) + 8'h01)
        else $error("pin edge on b not counted");
    wrap_16bit_b_a: assert property (mode_b == timer_pkg::mode_16bit && run_b && tick_b
        && mode_a != timer_pkg::mode_split && {cur.b_hi, cur.b_lo} == 16'hffff
        && byte_write == 4'h0 |=> {timer_b_high_byte, timer_b_low_byte} == 16'h0000
        && timer_b_overflow_flag) else $error("16-bit wrap on b wrong");
    low_top_a: assert property (mode_a == timer_pkg::mode_13bit && byte_write == 4'h0
        |=> timer_a_low_byte[7:5] == $past(cur.a_lo[7:5]))
        else $error("13-bit mode touched low byte top bits");
    b_pulse_a: assert property (ovf_b |=> timer_b_overflow_pulse)
        else $error("overflow pulse of b missing");
    split_pin_a: assert property (mode_a == timer_pkg::mode_split && timer_a_count_select
        && run_a && fall_a && byte_write == 4'h0
        |=> timer_a_low_byte == $past(cur.a_lo) + 8'h01) else $error("split pin edge lost");

    split_run_c: cover property (mode_a == timer_pkg::mode_split && ovf_split_hi);
    pin_edge_c: cover property (timer_a_count_select && fall_a && run_a);
    reload_c: cover property (mode_b == timer_pkg::mode_reload && ovf_b);
    clear_race_c: cover property (ovf_a && timer_a_flag_clear);
    b_pulse_c: cover property (timer_b_overflow_pulse && mode_a == timer_pkg::mode_split);

endmodule // dual_counter_timer_unit

//--- sim/event_source.sv
`timescale 1ns/1ps

module event_source (
    output logic pin
);
    // idle level is high so a burst starts with a clean falling edge
    initial begin
        pin = 1'h1;
    end

    // three clocks per level: above the two-clock minimum, below a glitch-free margin
    task automatic burst(input int n, ref logic clk);
        for (int i = 0; i < n; i++) begin
            repeat (3) @(negedge clk);
            pin = 1'h0;
            repeat (3) @(negedge clk);
            pin = 1'h1;
        end
    endtask
endmodule // event_source

//--- sim/test_dual_counter_timer_unit.sv
`timescale 1ns/1ps

`define check(what, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            n_fail++; \
            $display("unexpected %s expected %h seen %h", what, exp, got); \
        end \
    end

module test_dual_counter_timer_unit;
    logic clk_sys, resetn, ext_osc, gate_pin_a, gate_pin_b, count_pin_a, count_pin_b;
    logic [3:0] timer_mode_select_bits, byte_write;
    logic [1:0] timer_clock_select_bits, clock_scale_bits, timer_c_clock_select;
    logic timer_a_run_bit, timer_b_run_bit, timer_a_count_select, timer_b_count_select;
    logic timer_a_gate_bit, timer_b_gate_bit, timer_a_irq_enable, timer_b_irq_enable;
    logic timer_a_flag_clear, timer_b_flag_clear, timer_c_run, timer_c_split;
    logic [7:0] write_data, timer_c_reload_low, timer_c_reload_high;
    logic [7:0] timer_a_low_byte, timer_a_high_byte, timer_b_low_byte, timer_b_high_byte;
    logic [7:0] timer_c_low_byte, timer_c_high_byte;
    logic timer_a_overflow_flag, timer_b_overflow_flag, timer_a_irq, timer_b_irq;
    logic timer_b_overflow_pulse, timer_c_low_overflow, timer_c_high_overflow;
    int n_fail, comparisons;
    logic [1:0] scales [3] = '{2'h0, 2'h1, 2'h2};
    int spans [3] = '{48, 40, 96};
    logic [7:0] ticks [3] = '{8'h04, 8'h0a, 8'h02};

    dual_counter_timer_unit i_dut (
        .clk_sys, .resetn, .timer_mode_select_bits, .timer_clock_select_bits,
        .clock_scale_bits, .timer_a_run_bit, .timer_b_run_bit, .timer_a_count_select,
        .timer_b_count_select, .timer_a_gate_bit, .timer_b_gate_bit, .timer_a_irq_enable,
        .timer_b_irq_enable, .count_pin_a, .count_pin_b, .gate_pin_a, .gate_pin_b, .ext_osc,
        .byte_write, .write_data, .timer_a_flag_clear, .timer_b_flag_clear, .timer_c_run,
        .timer_c_split, .timer_c_clock_select, .timer_c_reload_low, .timer_c_reload_high,
        .timer_a_low_byte, .timer_a_high_byte, .timer_b_low_byte, .timer_b_high_byte,
        .timer_a_overflow_flag, .timer_b_overflow_flag, .timer_a_irq, .timer_b_irq,
        .timer_b_overflow_pulse, .timer_c_low_byte, .timer_c_high_byte,
        .timer_c_low_overflow, .timer_c_high_overflow
    );
    event_source i_src_a (.pin(count_pin_a));
    event_source i_src_b (.pin(count_pin_b));

    task automatic conclude();
        if (n_fail == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] sel, input logic [7:0] d);
        @(negedge clk_sys);
        byte_write = sel;
        write_data = d;
        @(negedge clk_sys);
        byte_write = 4'h0;
    endtask

    // the run bits stay up for exactly n rising edges
    task automatic pulse_run(input logic a, input logic b, input int n);
        @(negedge clk_sys);
        timer_a_run_bit = a;
        timer_b_run_bit = b;
        repeat (n) @(negedge clk_sys);
        timer_a_run_bit = 1'h0;
        timer_b_run_bit = 1'h0;
    endtask

    task automatic clr();
        @(negedge clk_sys);
        {timer_a_flag_clear, timer_b_flag_clear} = 2'h3;
        @(negedge clk_sys);
        {timer_a_flag_clear, timer_b_flag_clear} = 2'h0;
    endtask

    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    initial begin
        #500_000;
        n_fail++;
        conclude();
    end

    initial begin
        n_fail = 0;
        comparisons = 0;
        {resetn, ext_osc, gate_pin_a, gate_pin_b, timer_mode_select_bits, byte_write} = '0;
        {clock_scale_bits, timer_c_clock_select, timer_a_run_bit, timer_b_run_bit} = '0;
        {timer_a_count_select, timer_b_count_select, timer_a_gate_bit, timer_b_gate_bit} = '0;
        {timer_a_irq_enable, timer_b_irq_enable, timer_a_flag_clear, timer_b_flag_clear} = '0;
        {timer_c_run, timer_c_split, write_data, timer_c_reload_low, timer_c_reload_high} = '0;
        timer_clock_select_bits = 2'h3;
        repeat (5) @(negedge clk_sys);
        resetn = 1'h1;
        `check("counts", 32'h0000_0000, {timer_a_high_byte, timer_a_low_byte,
            timer_b_high_byte, timer_b_low_byte});
        `check("flags", 2'h0, {timer_a_overflow_flag, timer_b_overflow_flag});
        // a in 13-bit from 1ffe, b in 16-bit from ffff: a wraps on the second tick, b on the first
        timer_mode_select_bits = 4'h4;
        {timer_a_irq_enable, timer_b_irq_enable} = 2'h3;
        wr(4'h2, 8'hff);
        wr(4'h1, 8'hfe);
        wr(4'hc, 8'hff);
        pulse_run(1'h1, 1'h1, 2);
        `check("a 13-bit", 13'h0000, {timer_a_high_byte, timer_a_low_byte[4:0]});
        `check("a flag", 1'h1, timer_a_overflow_flag);
        `check("b 16-bit", 16'h0001, {timer_b_high_byte, timer_b_low_byte});
        `check("b flag", 1'h1, timer_b_overflow_flag);
        `check("irqs", 2'h3, {timer_a_irq, timer_b_irq});
        @(negedge clk_sys);
        timer_a_irq_enable = 1'h0;
        @(negedge clk_sys);
        `check("irqs masked", 2'h1, {timer_a_irq, timer_b_irq});
        clr();
        `check("flags cleared", 2'h0, {timer_a_overflow_flag, timer_b_overflow_flag});
        // a reloads, b in mode 3 must stay put
        timer_mode_select_bits = 4'he;
        wr(4'h2, 8'hf0);
        wr(4'h1, 8'hfe);
        pulse_run(1'h1, 1'h1, 3);
        `check("a reload", 16'hf0f1, {timer_a_high_byte, timer_a_low_byte});
        `check("a flag", 1'h1, timer_a_overflow_flag);
        `check("b idle", 16'h0001, {timer_b_high_byte, timer_b_low_byte});
        clr();
        // prescaled ticks: any window of whole periods holds a fixed tick count
        timer_mode_select_bits = 4'hd;
        timer_clock_select_bits = 2'h2;
        for (int i = 0; i < 3; i++) begin
            clock_scale_bits = scales[i];
            wr(4'h3, 8'h00);
            pulse_run(1'h1, 1'h0, spans[i]);
            `check("prescaled", {8'h00, ticks[i]}, {timer_a_high_byte, timer_a_low_byte});
        end
        clock_scale_bits = 2'h3;
        wr(4'h3, 8'h00);
        timer_a_run_bit = 1'h1;
        repeat (16) begin
            repeat (2) @(negedge clk_sys);
            ext_osc = 1'h1;
            repeat (2) @(negedge clk_sys);
            ext_osc = 1'h0;
        end
        repeat (8) @(negedge clk_sys);
        timer_a_run_bit = 1'h0;
        `check("ext div8", 16'h0002, {timer_a_high_byte, timer_a_low_byte});
        // pin counting on both timers at once, then a gated
        timer_clock_select_bits = 2'h3;
        timer_mode_select_bits = 4'h5;
        wr(4'hf, 8'h00);
        {timer_a_count_select, timer_b_count_select, timer_a_run_bit, timer_b_run_bit} = '1;
        fork
            i_src_a.burst(5, clk_sys);
            i_src_b.burst(3, clk_sys);
        join
        repeat (6) @(negedge clk_sys);
        `check("a pin count", 8'h05, timer_a_low_byte);
        `check("b pin count", 8'h03, timer_b_low_byte);
        timer_a_gate_bit = 1'h1;
        i_src_a.burst(2, clk_sys);
        repeat (6) @(negedge clk_sys);
        `check("gate closed", 8'h05, timer_a_low_byte);
        gate_pin_a = 1'h1;
        repeat (4) @(negedge clk_sys);
        i_src_a.burst(2, clk_sys);
        repeat (6) @(negedge clk_sys);
        `check("gate open", 8'h07, timer_a_low_byte);
        {timer_a_count_select, timer_b_count_select, timer_a_run_bit, timer_b_run_bit} = '0;
        timer_a_gate_bit = 1'h0;
        // split: low half on a's run, high half on b's run, b free-running without flag
        timer_mode_select_bits = 4'h7;
        wr(4'hf, 8'hff);
        @(negedge clk_sys);
        `check("b wrap pulse", 1'h1, timer_b_overflow_pulse);
        pulse_run(1'h1, 1'h0, 1);
        `check("split halves", 16'hff00, {timer_a_high_byte, timer_a_low_byte});
        `check("split flags", 2'h2, {timer_a_overflow_flag, timer_b_overflow_flag});
        `check("b in split", 16'h0002, {timer_b_high_byte, timer_b_low_byte});
        pulse_run(1'h0, 1'h1, 1);
        `check("split high", 16'h0000, {timer_a_high_byte, timer_a_low_byte});
        `check("b flag", 1'h1, timer_b_overflow_flag);
        `check("b in split", 16'h0004, {timer_b_high_byte, timer_b_low_byte});
        timer_mode_select_bits = 4'hf;
        pulse_run(1'h1, 1'h1, 2);
        `check("b stopped", 16'h0004, {timer_b_high_byte, timer_b_low_byte});
        `check("split both", 16'h0202, {timer_a_high_byte, timer_a_low_byte});
        timer_a_count_select = 1'h1;
        timer_a_run_bit = 1'h1;
        i_src_a.burst(2, clk_sys);
        repeat (6) @(negedge clk_sys);
        timer_a_run_bit = 1'h0;
        `check("split pin", 16'h0204, {timer_a_high_byte, timer_a_low_byte});
        // third timer, split halves with reload, first wrap on tick 256
        {timer_c_split, timer_c_reload_low, timer_c_reload_high} = {1'h1, 8'hfe, 8'hfe};
        @(negedge clk_sys);
        timer_c_run = 1'h1;
        repeat (256) @(negedge clk_sys);
        timer_c_run = 1'h0;
        `check("c wraps", 2'h3, {timer_c_low_overflow, timer_c_high_overflow});
        `check("c reload", 16'hfefe, {timer_c_high_byte, timer_c_low_byte});
        timer_c_clock_select = 2'h1;
        @(negedge clk_sys);
        timer_c_run = 1'h1;
        repeat (12) @(negedge clk_sys);
        timer_c_run = 1'h0;
        `check("c div12", 16'hffff, {timer_c_high_byte, timer_c_low_byte});
        {timer_c_split, timer_c_clock_select} = 3'h0;
        @(negedge clk_sys);
        timer_c_run = 1'h1;
        @(negedge clk_sys);
        timer_c_run = 1'h0;
        `check("c full", 17'h1_fefe, {timer_c_high_overflow, timer_c_high_byte, timer_c_low_byte});
        conclude();
    end
endmodule // test_dual_counter_timer_unit
